/* File: hw/tsi_pkg.sv */
// Constants shared by the TDM stream timing interface.
// Assumes a single 25 MHz system clock and a 32-bit AHB-Lite register bus.
package tsi_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NUM_STREAMS     = 32;
  localparam int NUM_HIZ_STREAMS = 16;

  // ----------------------------------------------------------------------
  // Register byte offsets; page numbers for address bits 11:7
  // ----------------------------------------------------------------------
  localparam logic [11:0] REG_CONTROL  = 12'h000;
  localparam logic [11:0] REG_MODE     = 12'h004;
  localparam logic [11:0] REG_HIZ_MASK = 12'h008;
  localparam logic [11:0] REG_STATUS   = 12'h00C;
  localparam logic [4:0]  REG_IN_PAGE  = 5'h02;
  localparam logic [4:0]  REG_OUT_PAGE = 5'h04;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_POLARITY_BIT = 0;
  localparam int CTRL_GCI_BIT      = 1;
  localparam int CTRL_EDGE_BIT     = 2;
  localparam int CTRL_LOOP_BIT     = 3;
  localparam int MODE_BIDIR_LO_BIT = 6;
  localparam int MODE_BIDIR_HI_BIT = 7;
  localparam int OUT_HIZ_BIT       = 2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0]  CONTROL_RESET  = 4'h0;
  localparam logic [1:0]  MODE_RESET     = 2'h0;
  localparam logic [31:0] HIZ_MASK_RESET = 32'h0000_0000;
  localparam logic [7:0]  PATTERN_RESET  = 8'hFF;

  // ----------------------------------------------------------------------
  // Stream rates
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {RATE_2M, RATE_4M, RATE_8M, RATE_16M} tsi_rate_t;

  // ----------------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------------
  localparam logic [11:0] FRAME_TICKS_4M  = 12'h200;
  localparam logic [11:0] FRAME_TICKS_8M  = 12'h400;
  localparam logic [11:0] FRAME_TICKS_16M = 12'h800;
  localparam logic [11:0] GCI_LOAD        = 12'h001;
  localparam logic [11:0] LOOP_FRAME_LAST = 12'h1FF;
  localparam int CLK_PERIOD_NS    = 40;
  localparam int LOOP_TICK_NS     = 244;
  localparam int LOOP_TICK_CYCLES =
    (LOOP_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] LOOP_TICK_LAST = 4'(LOOP_TICK_CYCLES - 1);

endpackage

/* File: hw/tsi_stream_lane.sv */
// One serial stream lane: bit timing, input capture, output drive.
// Assumes tick strobes and frame tick counts from the timing core.
`timescale 1ns/100ps
module tsi_stream_lane (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        tickStb,
  input  wire logic [11:0] tickCount,
  input  wire logic [1:0]  clkRate,
  input  wire logic        timingValid,
  input  wire logic [1:0]  inRate,
  input  wire logic [1:0]  outRate,
  input  wire logic        serialBitIn,
  input  wire logic [7:0]  patternByte,
  input  wire logic        streamHiz,
  input  wire logic [31:0] hizMask,
  input  wire logic        driveEnable,
  output logic      [7:0]  rxByte,
  output logic             serialOut,
  output logic             serialOutEn,
  output logic             hizCtrl
);

  // ----------------------------------------------------------------------
  // Bit position decode
  // ----------------------------------------------------------------------
  logic [2:0]  inShift;
  logic [2:0]  outShift;
  logic [11:0] inBitIdx;
  logic [11:0] outBitIdx;
  logic [11:0] inPhase;
  logic [11:0] outPhase;
  logic [11:0] inHalf;
  logic        inValid;
  logic        outValid;
  logic        chanHiz;
  logic [7:0]  shift_reg;
  logic [7:0]  shift_next;
  logic [7:0]  rx_reg;
  logic [7:0]  rx_next;
  logic        out_reg;
  logic        out_next;
  logic        oe_reg;
  logic        oe_next;
  logic        hiz_reg;
  logic        hiz_next;

  always_comb begin
    inShift   = {1'b0, clkRate} + 3'h1 - {1'b0, inRate};
    outShift  = {1'b0, clkRate} + 3'h1 - {1'b0, outRate};
    inValid   = timingValid && ({1'b0, inRate} <= {1'b0, clkRate} + 3'h1);
    outValid  = timingValid && ({1'b0, outRate} <= {1'b0, clkRate} + 3'h1);
    inBitIdx  = tickCount >> inShift;
    outBitIdx = tickCount >> outShift;
    inPhase   = tickCount & ((12'h001 << inShift) - 12'h001);
    outPhase  = tickCount & ((12'h001 << outShift) - 12'h001);
    inHalf    = (inShift == 3'h0) ? 12'h000 : (12'h001 << (inShift - 3'h1));
    chanHiz   = streamHiz | hizMask[outBitIdx[7:3]];
    shift_next = shift_reg;
    rx_next    = rx_reg;
    out_next   = out_reg;
    oe_next    = oe_reg;
    hiz_next   = hiz_reg;
    if (tickStb && inValid && inPhase == inHalf) begin
      shift_next = {shift_reg[6:0], serialBitIn};
      if (inBitIdx[2:0] == 3'h7) begin
        rx_next = {shift_reg[6:0], serialBitIn};
      end
    end
    if (tickStb && outValid && outPhase == 12'h000) begin
      out_next = patternByte[3'h7 - outBitIdx[2:0]];
      oe_next  = ~chanHiz;
      hiz_next = chanHiz;
    end
    if (!outValid) begin
      oe_next  = 1'b0;
      hiz_next = 1'b1;
    end
    if (!driveEnable) begin
      oe_next  = 1'b0;
      hiz_next = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      shift_reg <= 8'h00;
      rx_reg    <= 8'h00;
      out_reg   <= 1'b0;
      oe_reg    <= 1'b0;
      hiz_reg   <= 1'b1;
    end else begin
      shift_reg <= shift_next;
      rx_reg    <= rx_next;
      out_reg   <= out_next;
      oe_reg    <= oe_next;
      hiz_reg   <= hiz_next;
    end
  end

  assign rxByte      = rx_reg;
  assign serialOut   = out_reg;
  assign serialOutEn = oe_reg;
  assign hizCtrl     = hiz_reg;

endmodule

/* File: hw/tsi_timing_top.sv */
// TDM stream timing interface: frame timing, 32 lanes, AHB-Lite registers.
// Assumes pins are asynchronous to clk and one AHB-Lite master.
//
// Function
// - Pulse active low unless polarity bit set.
// - GCI select bit accepts GCI pulse position.
// - Boundary on falling edge, rising if selected.
// - Each input stream rate chosen independently.
// - Each output stream rate chosen independently.
// - Mode bits 7, 6 make outputs bidirectional.
// - Hi-z channel drives buffer control high.
// - Driven channel drives buffer control low.
// - Buffer controls only for streams 0 to 15.
// - Drive enable low: tristate, controls high.
//
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
module tsi_timing_top (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        timingClockInput,
  input  wire logic        framePulseInput,
  input  wire logic        streamOutputDriveEnable,
  input  wire logic [31:0] serialInputStreams,
  input  wire logic [31:0] serialOutputStreamsIn,
  output logic      [31:0] serialOutputStreamsOut,
  output logic      [31:0] serialOutputStreamsOe,
  output logic      [15:0] externalBufferHizControl
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic        clkSync1_reg;
  logic        clkSync2_reg;
  logic        clkPrev_reg;
  logic        fpSync1_reg;
  logic        fpSync2_reg;
  logic        odeSync1_reg;
  logic        odeSync2_reg;
  logic [31:0] inSync1_reg;
  logic [31:0] inSync2_reg;
  logic [31:0] ioSync1_reg;
  logic [31:0] ioSync2_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      clkSync1_reg <= 1'b0;
      clkSync2_reg <= 1'b0;
      clkPrev_reg  <= 1'b0;
      fpSync1_reg  <= 1'b1;
      fpSync2_reg  <= 1'b1;
      odeSync1_reg <= 1'b0;
      odeSync2_reg <= 1'b0;
      inSync1_reg  <= 32'h0000_0000;
      inSync2_reg  <= 32'h0000_0000;
      ioSync1_reg  <= 32'h0000_0000;
      ioSync2_reg  <= 32'h0000_0000;
    end else begin
      clkSync1_reg <= timingClockInput;
      clkSync2_reg <= clkSync1_reg;
      clkPrev_reg  <= clkSync2_reg;
      fpSync1_reg  <= framePulseInput;
      fpSync2_reg  <= fpSync1_reg;
      odeSync1_reg <= streamOutputDriveEnable;
      odeSync2_reg <= odeSync1_reg;
      inSync1_reg  <= serialInputStreams;
      inSync2_reg  <= inSync1_reg;
      ioSync1_reg  <= serialOutputStreamsIn;
      ioSync2_reg  <= ioSync1_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Register file and AHB-Lite slave
  // ----------------------------------------------------------------------
  logic [3:0]       control_reg;
  logic [3:0]       control_next;
  logic [1:0]       mode_reg;
  logic [1:0]       mode_next;
  logic [31:0]      hizMask_reg;
  logic [31:0]      hizMask_next;
  logic [31:0][1:0] inRate_reg;
  logic [31:0][1:0] inRate_next;
  logic [31:0][1:0] outRate_reg;
  logic [31:0][1:0] outRate_next;
  logic [31:0]      outHiz_reg;
  logic [31:0]      outHiz_next;
  logic [31:0][7:0] pattern_reg;
  logic [31:0][7:0] pattern_next;
  logic             wrPend_reg;
  logic             wrPend_next;
  logic [11:0]      wrAddr_reg;
  logic [11:0]      wrAddr_next;
  logic [31:0]      rdata_reg;
  logic [31:0]      rdata_next;
  logic [31:0][7:0] rxBytes;
  logic [11:0]      frameLen_reg;
  logic [15:0]      frameCount_reg;
  logic [1:0]       clkRate_reg;
  logic             timingValid_reg;
  logic             addrTaken;
  logic [4:0]       wIdx;
  logic [4:0]       rIdx;

  always_comb begin
    control_next = control_reg;
    mode_next    = mode_reg;
    hizMask_next = hizMask_reg;
    inRate_next  = inRate_reg;
    outRate_next = outRate_reg;
    outHiz_next  = outHiz_reg;
    pattern_next = pattern_reg;
    addrTaken    = hsel && hready && htrans[1];
    wrPend_next  = addrTaken && hwrite;
    wrAddr_next  = addrTaken ? haddr[11:0] : wrAddr_reg;
    wIdx         = wrAddr_reg[6:2];
    rIdx         = haddr[6:2];
    if (wrPend_reg && wrAddr_reg[1:0] == 2'h0) begin
      if (wrAddr_reg == tsi_pkg::REG_CONTROL) begin
        control_next = hwdata[3:0];
      end else if (wrAddr_reg == tsi_pkg::REG_MODE) begin
        mode_next = {hwdata[tsi_pkg::MODE_BIDIR_HI_BIT],
                     hwdata[tsi_pkg::MODE_BIDIR_LO_BIT]};
      end else if (wrAddr_reg == tsi_pkg::REG_HIZ_MASK) begin
        hizMask_next = hwdata;
      end else if (wrAddr_reg[11:7] == tsi_pkg::REG_IN_PAGE) begin
        inRate_next[wIdx] = hwdata[1:0];
      end else if (wrAddr_reg[11:7] == tsi_pkg::REG_OUT_PAGE) begin
        outRate_next[wIdx] = hwdata[1:0];
        outHiz_next[wIdx]  = hwdata[tsi_pkg::OUT_HIZ_BIT];
        pattern_next[wIdx] = hwdata[15:8];
      end
    end
    rdata_next = rdata_reg;
    if (addrTaken && !hwrite) begin
      rdata_next = 32'h0000_0000;
      if (haddr[1:0] != 2'h0) begin
        rdata_next = 32'h0000_0000;
      end else if (haddr[11:0] == tsi_pkg::REG_CONTROL) begin
        rdata_next = {28'h000_0000, control_next};
      end else if (haddr[11:0] == tsi_pkg::REG_MODE) begin
        rdata_next = {24'h00_0000, mode_next, 6'h00};
      end else if (haddr[11:0] == tsi_pkg::REG_HIZ_MASK) begin
        rdata_next = hizMask_next;
      end else if (haddr[11:0] == tsi_pkg::REG_STATUS) begin
        rdata_next = {frameCount_reg, 1'b0, timingValid_reg, clkRate_reg,
                      frameLen_reg};
      end else if (haddr[11:7] == tsi_pkg::REG_IN_PAGE) begin
        rdata_next = {16'h0000, rxBytes[rIdx], 6'h00, inRate_next[rIdx]};
      end else if (haddr[11:7] == tsi_pkg::REG_OUT_PAGE) begin
        rdata_next = {16'h0000, pattern_next[rIdx], 5'h00,
                      outHiz_next[rIdx], outRate_next[rIdx]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      control_reg <= tsi_pkg::CONTROL_RESET;
      mode_reg    <= tsi_pkg::MODE_RESET;
      hizMask_reg <= tsi_pkg::HIZ_MASK_RESET;
      inRate_reg  <= '0;
      outRate_reg <= '0;
      outHiz_reg  <= '0;
      pattern_reg <= {tsi_pkg::NUM_STREAMS{tsi_pkg::PATTERN_RESET}};
      wrPend_reg  <= 1'b0;
      wrAddr_reg  <= 12'h000;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      control_reg <= control_next;
      mode_reg    <= mode_next;
      hizMask_reg <= hizMask_next;
      inRate_reg  <= inRate_next;
      outRate_reg <= outRate_next;
      outHiz_reg  <= outHiz_next;
      pattern_reg <= pattern_next;
      wrPend_reg  <= wrPend_next;
      wrAddr_reg  <= wrAddr_next;
      rdata_reg   <= rdata_next;
    end
  end

  // ----------------------------------------------------------------------
  // Frame timing core
  // ----------------------------------------------------------------------
  logic        framePulsePolarity;
  logic        framePulseGciSelect;
  logic        clockEdgeSelect;
  logic        clockLoopbackSelect;
  logic        tick;
  logic        fpActive;
  logic        boundary;
  logic        fpPrev_reg;
  logic        fpPrev_next;
  logic [11:0] tickCount_reg;
  logic [11:0] tickCount_next;
  logic        tickStb_reg;
  logic        tickStb_next;
  logic [3:0]  loopCnt_reg;
  logic [3:0]  loopCnt_next;
  logic [11:0] frameLen_next;
  logic [15:0] frameCount_next;
  logic [1:0]  clkRate_next;
  logic        timingValid_next;

  always_comb begin
    framePulsePolarity  = control_reg[tsi_pkg::CTRL_POLARITY_BIT];
    framePulseGciSelect = control_reg[tsi_pkg::CTRL_GCI_BIT];
    clockEdgeSelect     = control_reg[tsi_pkg::CTRL_EDGE_BIT];
    clockLoopbackSelect = control_reg[tsi_pkg::CTRL_LOOP_BIT];
    fpActive = framePulsePolarity ? fpSync2_reg : ~fpSync2_reg;
    loopCnt_next = (loopCnt_reg == tsi_pkg::LOOP_TICK_LAST) ?
                   4'h0 : loopCnt_reg + 4'h1;
    if (clockLoopbackSelect) begin
      tick     = loopCnt_reg == tsi_pkg::LOOP_TICK_LAST;
      boundary = tickCount_reg == tsi_pkg::LOOP_FRAME_LAST;
    end else begin
      tick = clockEdgeSelect ? (clkSync2_reg & ~clkPrev_reg) :
                               (~clkSync2_reg & clkPrev_reg);
      boundary = fpActive & ~fpPrev_reg;
    end
    fpPrev_next     = fpPrev_reg;
    tickCount_next  = tickCount_reg;
    frameLen_next   = frameLen_reg;
    frameCount_next = frameCount_reg;
    tickStb_next    = tick;
    if (tick) begin
      fpPrev_next = fpActive;
      if (boundary) begin
        frameLen_next   = tickCount_reg + 12'h001 -
                          ((framePulseGciSelect && !clockLoopbackSelect) ?
                           tsi_pkg::GCI_LOAD : 12'h000);
        frameCount_next = frameCount_reg + 16'h0001;
        tickCount_next  = (framePulseGciSelect && !clockLoopbackSelect) ?
                          tsi_pkg::GCI_LOAD : 12'h000;
      end else begin
        tickCount_next = tickCount_reg + 12'h001;
      end
    end
    timingValid_next = 1'b1;
    unique case (frameLen_reg)
      tsi_pkg::FRAME_TICKS_4M:  clkRate_next = 2'h0;
      tsi_pkg::FRAME_TICKS_8M:  clkRate_next = 2'h1;
      tsi_pkg::FRAME_TICKS_16M: clkRate_next = 2'h2;
      default: begin
        clkRate_next     = 2'h0;
        timingValid_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fpPrev_reg      <= 1'b0;
      tickCount_reg   <= 12'h000;
      tickStb_reg     <= 1'b0;
      loopCnt_reg     <= 4'h0;
      frameLen_reg    <= 12'h000;
      frameCount_reg  <= 16'h0000;
      clkRate_reg     <= 2'h0;
      timingValid_reg <= 1'b0;
    end else begin
      fpPrev_reg      <= fpPrev_next;
      tickCount_reg   <= tickCount_next;
      tickStb_reg     <= tickStb_next;
      loopCnt_reg     <= loopCnt_next;
      frameLen_reg    <= frameLen_next;
      frameCount_reg  <= frameCount_next;
      clkRate_reg     <= clkRate_next;
      timingValid_reg <= timingValid_next;
    end
  end

  // ----------------------------------------------------------------------
  // Stream lanes
  // ----------------------------------------------------------------------
  logic [31:0] hizAll;

  for (genvar i = 0; i < tsi_pkg::NUM_STREAMS; i++) begin : gLane
    logic bitIn;
    assign bitIn = mode_reg[i / 16] ? ioSync2_reg[i] :
                                      inSync2_reg[i];
    tsi_stream_lane uLane (
      .clk         (clk),
      .srst        (srst),
      .tickStb     (tickStb_reg),
      .tickCount   (tickCount_reg),
      .clkRate     (clkRate_reg),
      .timingValid (timingValid_reg),
      .inRate      (inRate_reg[i]),
      .outRate     (outRate_reg[i]),
      .serialBitIn (bitIn),
      .patternByte (pattern_reg[i]),
      .streamHiz   (outHiz_reg[i]),
      .hizMask     (hizMask_reg),
      .driveEnable (odeSync2_reg),
      .rxByte      (rxBytes[i]),
      .serialOut   (serialOutputStreamsOut[i]),
      .serialOutEn (serialOutputStreamsOe[i]),
      .hizCtrl     (hizAll[i])
    );
  end

  assign externalBufferHizControl = hizAll[15:0];
  assign hrdata    = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule

/* File: testbench/tsi_timing_properties.sv */
// Port checker for the TDM stream timing interface.
// Assumes a bind onto tsi_timing_top in the bench top file.
`timescale 1ns/100ps
module tsi_timing_properties (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        streamOutputDriveEnable,
  input wire logic [31:0] serialOutputStreamsOut,
  input wire logic [31:0] serialOutputStreamsOe,
  input wire logic [15:0] externalBufferHizControl
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  ready_always_a: assert property (hreadyout)
    else $error("hreadyout low");
  okay_resp_a: assert property (!hresp)
    else $error("hresp not OKAY");
  rdata_holds_a: assert property ($changed(hrdata) |->
    $past(hsel && hready && htrans[1] && !hwrite))
    else $error("hrdata changed without a read");
  reset_state_a: assert property (disable iff (1'b0) srst |=>
    serialOutputStreamsOe == 32'h0 && hrdata == 32'h0 &&
    externalBufferHizControl == 16'hFFFF)
    else $error("outputs not in reset state");
  drive_off_a: assert property (
    !streamOutputDriveEnable [*5] |-> serialOutputStreamsOe == 32'h0)
    else $error("streams driven while drive enable low");
  ctrl_high_a: assert property (
    !streamOutputDriveEnable [*5] |-> externalBufferHizControl == 16'hFFFF)
    else $error("buffer controls low while drive enable low");
  hiz_tracks_a: assert property (
    externalBufferHizControl == ~serialOutputStreamsOe[15:0])
    else $error("buffer control disagrees with stream drive");
  bit_stands_a: assert property (
    $changed(serialOutputStreamsOut) |=> $stable(serialOutputStreamsOut) [*2])
    else $error("output bit shorter than a tick");
  cover property (hsel && htrans[1] && !hwrite);
  cover property (externalBufferHizControl[0] == 1'b0);
  cover property ($fell(streamOutputDriveEnable));
endmodule

/* File: testbench/tsi_tdm_source.sv */
// Far-side TDM source: timing clock, frame pulse and serial bytes.
// Assumes a 4.096 MHz style clock scaled to a 320 ns period.
`timescale 1ns/100ps
module tsi_tdm_source (
  input  wire logic        holdPins,
  input  wire logic        activeHigh,
  input  wire logic        risingSel,
  input  wire logic        gciSel,
  input  wire logic [31:0] fastMask,
  output logic             timingClock,
  output logic             framePulse,
  output logic      [31:0] dataIn,
  output logic      [31:0] dataOut
);
  localparam logic [7:0] BYTE_IN  = 8'hA5;
  localparam logic [7:0] BYTE_OUT = 8'h5A;
  localparam int         TICKS    = 512;
  int tick;
  int bitNum;
  logic pulseNow;
  // --------------------------------------------------------------------
  // Clock, pulse and data, changed half a period before sampling.
  // --------------------------------------------------------------------
  initial begin
    timingClock = 1'b0;
    framePulse = 1'b1;
    dataIn = 32'h0;
    dataOut = 32'h0;
    tick = 0;
    #13;
    forever begin
      timingClock = holdPins ? 1'b0 : !risingSel;
      pulseNow = (tick == (gciSel ? 1 : 0)) ~^ activeHigh;
      framePulse = pulseNow | holdPins;
      for (int s = 0; s < 32; s++) begin
        bitNum = fastMask[s] ? tick : tick / 2;
        dataIn[s] = BYTE_IN[7 - bitNum % 8];
        dataOut[s] = BYTE_OUT[7 - bitNum % 8];
      end
      #160;
      timingClock = holdPins ? 1'b0 : risingSel;
      #160;
      tick = (tick + 1) % TICKS;
    end
  end
endmodule

/* File: testbench/tdm_stream_timing_interface_bench.sv */
// Self-checking bench for the TDM stream timing interface.
// Assumes the package, design, checker and source are compiled first.
`timescale 1ns/100ps
module tdm_stream_timing_interface_bench;
  localparam int FRAME = 4096;
  logic        clk      = 1'b0;
  logic        srst     = 1'b1;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [2:0]  hsize    = 3'h2;
  logic [31:0] hwdata   = 32'h0;
  logic        driveEn  = 1'b1;
  logic        polHigh  = 1'b0;
  logic        riseSel  = 1'b0;
  logic        gciSel   = 1'b0;
  logic [31:0] fastMask = 32'h0;
  logic        holdPins = 1'b0;
  logic [31:0] hrdata, sIn, sidePin, pinIn, sOut, sOe, rdVal;
  logic [15:0] hizCtl;
  logic        hreadyout, hresp, ck, fp;
  logic [3:0]  cfg [4] = '{4'h0, 4'h1, 4'h4, 4'h2};
  int          failCount = 0;
  int          checks = 0;
  int          c0, c1, c2;
  always #20 clk = ~clk;
  tsi_tdm_source i_source (.holdPins(holdPins), .activeHigh(polHigh),
    .risingSel(riseSel),
    .gciSel(gciSel), .fastMask(fastMask), .timingClock(ck),
    .framePulse(fp), .dataIn(sIn), .dataOut(sidePin));
  assign pinIn = (sOe & sOut) | (~sOe & sidePin);
  tsi_timing_top i_dut (.clk(clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timingClockInput(ck),
    .framePulseInput(fp), .streamOutputDriveEnable(driveEn),
    .serialInputStreams(sIn), .serialOutputStreamsIn(pinIn),
    .serialOutputStreamsOut(sOut), .serialOutputStreamsOe(sOe),
    .externalBufferHizControl(hizCtl));
  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdVal = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdChk(input logic [31:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdVal & m, exp);
  endtask
  task automatic printVerdict;
    $display("Checks %0d, mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rdChk(32'h0, 32'hFFFFFFFF, 32'h0);
    rdChk(32'h4, 32'hFFFFFFFF, 32'h0);
    rdChk(32'h8, 32'hFFFFFFFF, 32'h0);
    rdChk(32'h100, 32'h3, 32'h0);
    rdChk(32'h200, 32'hFFFF, 32'hFF00);
    bus(1'b1, 32'hF0, 32'hFFFFFFFF);
    rdChk(32'hF0, 32'hFFFFFFFF, 32'h0);
    fastMask <= 32'h2;
    bus(1'b1, 32'h104, 32'h1);
    for (int i = 0; i < 4; i++) begin
      polHigh <= cfg[i][0];
      gciSel <= cfg[i][1];
      riseSel <= cfg[i][2];
      bus(1'b1, 32'h0, {28'h0, cfg[i]});
      repeat (3 * FRAME) @(posedge clk);
      rdChk(32'h100, 32'hFF03, 32'hA500);
      rdChk(32'h104, 32'hFF03, 32'hA501);
      rdChk(32'hC, 32'h7FFF, 32'h4200);
    end
    polHigh <= 1'b0;
    gciSel <= 1'b0;
    riseSel <= 1'b0;
    bus(1'b1, 32'h0, 32'h0);
    bus(1'b1, 32'h204, 32'hFF01);
    bus(1'b1, 32'h208, 32'hFF02);
    bus(1'b1, 32'h8, 32'h1);
    repeat (3 * FRAME) @(posedge clk);
    c0 = 0;
    c1 = 0;
    c2 = 0;
    repeat (FRAME) begin
      @(negedge clk);
      c0 += int'(hizCtl[0] === 1'b1);
      c1 += int'(hizCtl[1] === 1'b1);
      c2 += int'(hizCtl[2] === 1'b1);
    end
    chk(32'(c0), 32'h80);
    chk(32'(c1), 32'h80);
    chk(32'(c2), 32'(FRAME));
    @(posedge clk);
    driveEn <= 1'b0;
    repeat (8) @(negedge clk);
    chk({16'h0, hizCtl}, 32'hFFFF);
    chk(sOe, 32'h0);
    @(posedge clk);
    driveEn <= 1'b1;
    bus(1'b1, 32'h8, 32'h0);
    bus(1'b1, 32'h4, 32'hC0);
    bus(1'b1, 32'h200, 32'hFF04);
    bus(1'b1, 32'h240, 32'hFF04);
    bus(1'b1, 32'h20C, 32'h3C00);
    repeat (3 * FRAME) @(posedge clk);
    rdChk(32'h100, 32'hFF00, 32'h5A00);
    rdChk(32'h140, 32'hFF00, 32'h5A00);
    rdChk(32'h10C, 32'hFF00, 32'h3C00);
    holdPins <= 1'b1;
    bus(1'b1, 32'h0, 32'h8);
    repeat (2 * FRAME) @(posedge clk);
    rdChk(32'hC, 32'h7FFF, 32'h4200);
    printVerdict;
  end
  initial begin
    repeat (100000) @(posedge clk);
    failCount++;
    printVerdict;
  end
endmodule
bind tsi_timing_top tsi_timing_properties i_props (.clk(clk), .srst(srst),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .streamOutputDriveEnable(streamOutputDriveEnable),
  .serialOutputStreamsOut(serialOutputStreamsOut),
  .serialOutputStreamsOe(serialOutputStreamsOe),
  .externalBufferHizControl(externalBufferHizControl));
